/* File: logic/vsr_regs.sv */
/*
  SPI-reached self-test, identification, flash counter and manual capture
  registers of the vibration sensor, with the automatic self-test sequencer.
  Assumes a host acting as SPI master (mode 3, 16-bit words), a capture engine
  and sample memory outside on the same clock, and a power-up reset.
*/
// Operation
// - Global command bit 2 runs automatic self-test
// - Delta outside limits sets fail flag
// - Misc bit 8 drives stimulus manually
// - Self-test enable clears itself when done
// - Misc control resets to 0x0003, reserved bits
// - Misc bits 1,0 enable supply compensation
// - Delta is signed 16 bits, 19.073 mg/LSB
// - Unique 24-bit lot code over two registers
// - Lot low byte in bits 15:8
// - Lot high register holds upper two bytes
// - Read-only 16-bit serial number
// - Flash counter increments on each write
// - Manual capture mode after start-up
// - Command bit 11 starts manual capture
// - Repeated buffer reads return successive samples
// - Reads pipelined, answer one transfer later
// - Violation flag holds until capture or clear command; fail flag also until next self-test
// - SPI traffic during capture flags violation
`timescale 1ns/1ps
`default_nettype none

module vsr_regs #(
  parameter logic [23:0] LOT_CODE = 24'h123456,     // Arbitrary value
  parameter logic [7:0] LOT_INTERNAL = 8'h00,       // Arbitrary value
  parameter logic [15:0] SERIAL_NUMBER = 16'h0001,  // Arbitrary value
  parameter logic signed [15:0] ST_MIN = 16'sh0010,
  parameter logic signed [15:0] ST_MAX = 16'sh0400
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // SPI pins
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // Sensing element
  input wire logic signed [15:0] accelSample,
  output logic stimulusOn,
  output logic auxOneComp,
  output logic auxTwoComp,
  // Capture engine and sample memory
  output logic captureStart,
  input wire logic captureBusy,
  output logic [vsr_pkg::BUF_AW-1:0] bufReadAddr,
  input wire logic [15:0] bufReadData,
  // Flash controller
  input wire logic flashWriteDone
);

  logic sclkS;
  logic csNS;
  logic mosiS;
  logic sclkD;
  logic csND;
  logic [15:0] rxShift;
  logic [15:0] txShift;
  logic [15:0] txWord;
  logic [4:0] bitCount;
  logic reloadNext;
  logic selfTestEn;
  logic capViol;
  logic stFail;
  logic captureBusyD;
  logic [15:0] flashCount;
  logic signed [15:0] selftestDelta;
  logic signed [15:0] baseline;
  logic [vsr_pkg::ST_CNT_W-1:0] settleCount;
  logic stimAuto;
  vsr_pkg::vsr_st_type stState;

  vsr_sync3 #(.RESET_VAL(1'b1)) syncSclk (.clk(clk), .reset(reset), .in(spiSclk), .out(sclkS));
  vsr_sync3 #(.RESET_VAL(1'b1)) syncCs (.clk(clk), .reset(reset), .in(spiCsN), .out(csNS));
  vsr_sync3 #(.RESET_VAL(1'b0)) syncMosi (.clk(clk), .reset(reset), .in(spiMosi), .out(mosiS));

  // SPI framing and decode
  wire sclkRise = sclkS & ~sclkD;
  wire sclkFall = ~sclkS & sclkD;
  wire csFall = ~csNS & csND;
  wire [15:0] rxNext = {rxShift[14:0], mosiS};
  wire frameDone = ~csNS & sclkRise & (bitCount == 5'(vsr_pkg::SPI_WORD_BITS - 1));
  wire isWrite = rxNext[vsr_pkg::SPI_WRITE_BIT];
  wire [6:0] addr = rxNext[14:8];
  wire [7:0] wdata = rxNext[7:0];
  wire [6:0] rdAddr = {addr[6:1], 1'b0};
  wire wrFrame = frameDone & isWrite;
  wire readReq = frameDone & ~isWrite;
  // Only misc control and global command decode writes; the rest are read-only
  wire wrMiscLow = wrFrame & (addr == vsr_pkg::ADDR_MISC_LOW);
  wire wrMiscHigh = wrFrame & (addr == vsr_pkg::ADDR_MISC_HIGH);
  wire wrGcmdLow = wrFrame & (addr == vsr_pkg::ADDR_GCMD_LOW);
  wire wrGcmdHigh = wrFrame & (addr == vsr_pkg::ADDR_GCMD_HIGH);
  wire bufRead = readReq & (rdAddr == vsr_pkg::ADDR_CAPT_BUF);
  // Manual capture is the only trigger this block issues
  wire capStartReq = wrGcmdHigh & wdata[vsr_pkg::GCMD_CAPTURE_BIT];
  wire stStartReq = wrGcmdLow & wdata[vsr_pkg::GCMD_SELFTEST_BIT];
  wire clearCmd = wrGcmdLow & wdata[vsr_pkg::GCMD_CLEAR_BIT];
  wire stenSet = wrMiscHigh & wdata[vsr_pkg::MISC_STEN_HIGH_BIT];
  wire captureDone = captureBusyD & ~captureBusy;
  wire violSet = frameDone & captureBusy;
  wire settleDone = (settleCount == vsr_pkg::ST_CNT_W'(vsr_pkg::ST_SETTLE_CYC - 1));
  wire signed [15:0] measDelta = accelSample - baseline;
  wire stOutside = (selftestDelta < ST_MIN) | (selftestDelta > ST_MAX);

  // Read-back words
  wire [15:0] miscRead = {7'h00, selfTestEn, 6'h00, auxTwoComp, auxOneComp};
  wire [15:0] diagRead = {10'h000, stFail, capViol, 4'h0};
  wire [15:0] lotLowRead = {LOT_CODE[7:0], LOT_INTERNAL};
  wire [15:0] lotHighRead = LOT_CODE[23:8];
  wire [15:0] readData =
    (rdAddr == vsr_pkg::ADDR_CAPT_BUF) ? bufReadData :
    (rdAddr == vsr_pkg::ADDR_MISC_LOW) ? miscRead :
    (rdAddr == vsr_pkg::ADDR_SELFTEST_DELTA) ? selftestDelta :
    (rdAddr == vsr_pkg::ADDR_DIAG) ? diagRead :
    (rdAddr == vsr_pkg::ADDR_LOT_LOW) ? lotLowRead :
    (rdAddr == vsr_pkg::ADDR_LOT_HIGH) ? lotHighRead :
    (rdAddr == vsr_pkg::ADDR_SERIAL) ? SERIAL_NUMBER :
    (rdAddr == vsr_pkg::ADDR_FLASH_COUNT) ? flashCount :
    16'h0000;

  // Serial shifter; MISO changes on falling SCLK so the host samples on rising
  always_ff @(posedge clk) begin
    if (reset) begin
      sclkD <= 1'b1;
      csND <= 1'b1;
      rxShift <= 16'h0000;
      bitCount <= 5'h00;
      spiMisoOe <= 1'b0;
    end else begin
      sclkD <= sclkS;
      csND <= csNS;
      spiMisoOe <= ~csNS;
      if (csNS) begin
        bitCount <= 5'h00;
      end else if (sclkRise) begin
        rxShift <= rxNext;
        bitCount <= frameDone ? 5'h00 : bitCount + 5'h01;
      end
    end
  end

  // The answer to a read leaves in the following transfer
  always_ff @(posedge clk) begin
    if (reset) begin
      txWord <= 16'h0000;
      txShift <= 16'h0000;
      spiMiso <= 1'b0;
      reloadNext <= 1'b0;
    end else begin
      if (readReq) begin
        txWord <= readData;
      end
      if (csFall) begin
        // MSB stays on the line through the first falling SCLK of the frame
        spiMiso <= txWord[15];
        txShift <= txWord;
        reloadNext <= 1'b0;
      end else if (sclkFall & reloadNext) begin
        spiMiso <= txWord[15];
        txShift <= {txWord[14:0], 1'b0};
        reloadNext <= 1'b0;
      end else begin
        if (sclkFall & ~csNS) begin
          spiMiso <= txShift[15];
          txShift <= {txShift[14:0], 1'b0};
        end
        if (frameDone) begin
          reloadNext <= 1'b1;
        end
      end
    end
  end

  // Misc control; manual stimulus ends with the capture that follows it
  always_ff @(posedge clk) begin
    if (reset) begin
      auxOneComp <= vsr_pkg::MISC_RESET[vsr_pkg::MISC_COMP_ONE_BIT];
      auxTwoComp <= vsr_pkg::MISC_RESET[vsr_pkg::MISC_COMP_TWO_BIT];
      selfTestEn <= vsr_pkg::MISC_RESET[vsr_pkg::MISC_STEN_BIT];
    end else begin
      if (wrMiscLow) begin
        auxOneComp <= wdata[vsr_pkg::MISC_COMP_ONE_BIT];
        auxTwoComp <= wdata[vsr_pkg::MISC_COMP_TWO_BIT];
      end
      if (stenSet) begin
        selfTestEn <= 1'b1;
      end else if (captureDone | wrMiscHigh) begin
        selfTestEn <= 1'b0;
      end
    end
  end

  // Capture command, buffer read pointer and flash counter
  always_ff @(posedge clk) begin
    if (reset) begin
      captureStart <= 1'b0;
      captureBusyD <= 1'b0;
      bufReadAddr <= '0;
      flashCount <= 16'h0000;
    end else begin
      captureStart <= capStartReq;
      captureBusyD <= captureBusy;
      if (capStartReq) begin
        bufReadAddr <= '0;
      end else if (bufRead) begin
        bufReadAddr <= bufReadAddr + vsr_pkg::BUF_AW'(1);
      end
      if (flashWriteDone) begin
        flashCount <= flashCount + 16'h0001;
      end
    end
  end

  // Automatic self-test: baseline, drive, measure, judge
  always_ff @(posedge clk) begin
    if (reset) begin
      stState <= vsr_pkg::ST_IDLE;
      settleCount <= '0;
      baseline <= 16'sh0000;
      selftestDelta <= 16'sh0000;
      stimAuto <= 1'b0;
      stimulusOn <= 1'b0;
    end else begin
      stimulusOn <= stimAuto | selfTestEn;
      unique case (stState)
        vsr_pkg::ST_IDLE: begin
          settleCount <= '0;
          if (stStartReq) begin
            stState <= vsr_pkg::ST_BASE;
          end
        end
        vsr_pkg::ST_BASE: begin
          settleCount <= settleDone ? '0 : settleCount + vsr_pkg::ST_CNT_W'(1);
          if (settleDone) begin
            baseline <= accelSample;
            stimAuto <= 1'b1;
            stState <= vsr_pkg::ST_DRIVE;
          end
        end
        vsr_pkg::ST_DRIVE: begin
          settleCount <= settleDone ? '0 : settleCount + vsr_pkg::ST_CNT_W'(1);
          if (settleDone) begin
            selftestDelta <= measDelta;
            stimAuto <= 1'b0;
            stState <= vsr_pkg::ST_MEAS;
          end
        end
        vsr_pkg::ST_MEAS: begin
          stState <= vsr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Sticky flags: hardware set wins over capture start and clear command
  always_ff @(posedge clk) begin
    if (reset) begin
      stFail <= 1'b0;
      capViol <= 1'b0;
    end else begin
      if (stState == vsr_pkg::ST_MEAS) begin
        stFail <= stOutside;
      end else if (capStartReq | clearCmd) begin
        stFail <= 1'b0;
      end
      if (violSet) begin
        capViol <= 1'b1;
      end else if (capStartReq | clearCmd) begin
        capViol <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_misc_reset_value: assert property ($past(reset) |-> miscRead == vsr_pkg::MISC_RESET)
    else $error("misc control not at reset value");
  chk_st_stimulus_drive: assert property (stState == vsr_pkg::ST_DRIVE |=> stimulusOn)
    else $error("stimulus off during self-test drive");
  chk_selftest_delta_store: assert property ((stState == vsr_pkg::ST_DRIVE) && settleDone
    |=> selftestDelta == $past(accelSample) - $past(baseline))
    else $error("self-test delta not stored");
  chk_st_flag_result: assert property (stState == vsr_pkg::ST_MEAS
    |=> stFail == ($past(selftestDelta) < ST_MIN || $past(selftestDelta) > ST_MAX))
    else $error("self-test flag disagrees with limits");
  chk_sten_manual_set: assert property (stenSet |=> selfTestEn ##1 stimulusOn)
    else $error("manual self-test not active");
  chk_sten_auto_clear: assert property (captureDone && !stenSet |=> !selfTestEn)
    else $error("self-test enable not cleared");
  chk_comp_enable_bits: assert property (wrMiscLow
    |=> auxOneComp == $past(wdata[0]) && auxTwoComp == $past(wdata[1]))
    else $error("supply compensation enables wrong");
  chk_capture_start_pulse: assert property (capStartReq
    |=> captureStart && bufReadAddr == '0 ##1 !captureStart || $past(capStartReq))
    else $error("capture start pulse wrong");
  chk_buf_read_advance: assert property (bufRead && !capStartReq
    |=> bufReadAddr == $past(bufReadAddr) + vsr_pkg::BUF_AW'(1))
    else $error("buffer pointer did not advance");
  chk_read_pipeline: assert property (readReq |=> txWord == $past(readData))
    else $error("read answer not queued");
  chk_viol_set_hold: assert property (violSet |=> capViol)
    else $error("capture violation not flagged");
  chk_flag_clear_cmd: assert property (clearCmd && !violSet |=> !capViol)
    else $error("clear command did not clear flag");
  chk_flag_hold: assert property (capViol && !capStartReq && !clearCmd |=> capViol)
    else $error("flag dropped without clear");
  chk_flash_count_inc: assert property (flashWriteDone
    |=> flashCount == $past(flashCount) + 16'h0001)
    else $error("flash counter did not increment");

  cov_selftest_done: cover property (stState == vsr_pkg::ST_MEAS ##1 stState == vsr_pkg::ST_IDLE);
  cov_buffer_read: cover property (capStartReq ##[1:1000] bufRead);
  cov_capture_violation: cover property (violSet);
  cov_manual_selftest: cover property (stenSet ##[1:1000] captureDone);

endmodule : vsr_regs

`default_nettype wire

/* File: logic/vsr_pkg.sv */
/*
  Shared constants for the vibration sensor control and information registers:
  SPI word layout, register addresses, field positions, reset values and the
  self-test sequencer states.
  Assumes a 20 MHz core clock and 16-bit SPI words.
*/
package vsr_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 50;

  // Settling time of the sensing element around each self-test step
  localparam int ST_SETTLE_NS = 100000;
  localparam int ST_SETTLE_CYC = (ST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST_CNT_W = 12;

  // SPI word: [15] write, [14:8] address, [7:0] write data
  localparam int SPI_WORD_BITS = 16;
  localparam int SPI_WRITE_BIT = 15;

  // Register addresses; odd address is the high byte of a word
  localparam logic [6:0] ADDR_FLASH_COUNT = 7'h00;
  localparam logic [6:0] ADDR_CAPT_BUF = 7'h14;
  localparam logic [6:0] ADDR_MISC_LOW = 7'h34;
  localparam logic [6:0] ADDR_MISC_HIGH = 7'h35;
  localparam logic [6:0] ADDR_SELFTEST_DELTA = 7'h38;
  localparam logic [6:0] ADDR_DIAG = 7'h3c;
  localparam logic [6:0] ADDR_GCMD_LOW = 7'h3e;
  localparam logic [6:0] ADDR_GCMD_HIGH = 7'h3f;
  localparam logic [6:0] ADDR_LOT_LOW = 7'h52;
  localparam logic [6:0] ADDR_LOT_HIGH = 7'h54;
  localparam logic [6:0] ADDR_SERIAL = 7'h58;

  // Global command: bits 2 and 4 in the low byte, bit 11 is bit 3 of the high byte
  localparam int GCMD_SELFTEST_BIT = 2;
  localparam int GCMD_CLEAR_BIT = 4;
  localparam int GCMD_CAPTURE_BIT = 3;

  // Misc control fields
  localparam logic [15:0] MISC_RESET = 16'h0003;
  localparam int MISC_COMP_ONE_BIT = 0;
  localparam int MISC_COMP_TWO_BIT = 1;
  localparam int MISC_STEN_BIT = 8;
  localparam int MISC_STEN_HIGH_BIT = 0;

  // Diagnostic flag positions
  localparam int DIAG_CAP_VIOL_BIT = 4;
  localparam int DIAG_ST_FAIL_BIT = 5;

  // Capture buffer
  localparam int BUF_DEPTH = 1024;
  localparam int BUF_AW = 10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BASE = 2'b01,
    ST_DRIVE = 2'b10,
    ST_MEAS = 2'b11
  } vsr_st_type;

endpackage : vsr_pkg

/* File: logic/vsr_sync3.sv */
/*
  Three-stage input synchroniser with agreement filter.
  Assumes an asynchronous single-bit input and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module vsr_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin side and synchronised level
  input wire logic in,
  output logic out
);

  logic s1;
  logic s2;
  logic s3;

  // A change is accepted only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      out <= RESET_VAL;
    end else begin
      s1 <= in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        out <= s2;
      end
    end
  end

endmodule : vsr_sync3

`default_nettype wire

/* File: sim/vsr_host_model.sv */
/*
  Host processor model: SPI master, mode 3, 16-bit words, MSB first.
  Assumes the bench calls xfer and the core clock paces the link.
*/
`timescale 1ns/1ps
`default_nettype none

module vsr_host_model #(
  parameter int HALF_CLK = 8
) (
  // Core clock
  input wire logic clk,
  // SPI pins
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic spiMiso
);
  initial begin
    spiSclk = 1'b1;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end

  // Clock stands high outside frames; pins move on the falling core edge
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk);
    spiCsN = 1'b0;
    repeat (HALF_CLK) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      spiSclk = 1'b0;
      spiMosi = tx[i];
      repeat (HALF_CLK) @(negedge clk);
      spiSclk = 1'b1;
      rx[i] = spiMiso;
      repeat (HALF_CLK) @(negedge clk);
    end
    spiCsN = 1'b1;
    // Released data line has no pull: show a value the design must not use
    spiMosi = ~tx[0];
    repeat (HALF_CLK) @(negedge clk);
  endtask : xfer
endmodule : vsr_host_model
`default_nettype wire

/* File: sim/vsr_regs_tb.sv */
/*
  Self-checking bench for the vibration sensor register block.
  Assumes the host model above; the bench plays sensor, memory,
  capture engine and flash controller.
*/
`timescale 1ns/1ps
`default_nettype none

module vsr_regs_tb;
  localparam logic [23:0] LOT = 24'h5ce17a; // Arbitrary value
  localparam logic [15:0] SER = 16'h2b4d; // Arbitrary value
  localparam logic signed [15:0] STMIN = 16'sh0010;
  localparam logic signed [15:0] STMAX = 16'sh0400;
  logic clk, reset, spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe;
  logic stimulusOn, auxOneComp, auxTwoComp, captureStart;
  logic captureBusy, flashWriteDone;
  logic signed [15:0] accelSample = 16'sh0000;
  logic signed [15:0] base = 16'sh0000;
  logic signed [15:0] dlt = 16'sh0000;
  logic signed [15:0] stVals [4];
  logic [vsr_pkg::BUF_AW-1:0] bufReadAddr, startAddr;
  logic [15:0] bufReadData, rx;
  logic [7:0] dat;
  int fails = 0, nChecks = 0, cycles = 0, starts = 0, nf;

  vsr_regs #(.LOT_CODE(LOT), .LOT_INTERNAL(8'h00), .SERIAL_NUMBER(SER),
    .ST_MIN(STMIN), .ST_MAX(STMAX)) DUT (.clk(clk), .reset(reset),
    .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .accelSample(accelSample), .stimulusOn(stimulusOn),
    .auxOneComp(auxOneComp), .auxTwoComp(auxTwoComp), .captureStart(captureStart),
    .captureBusy(captureBusy), .bufReadAddr(bufReadAddr), .bufReadData(bufReadData),
    .flashWriteDone(flashWriteDone));
  vsr_host_model host (.clk(clk), .spiSclk(spiSclk), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(spiMiso));

  function automatic logic [15:0] sampleAt(input logic [9:0] a);
    return {a, 6'h00} ^ 16'h5a3c;
  endfunction : sampleAt
  function automatic logic [15:0] stFlag(input logic signed [15:0] d);
    return (d < STMIN || d > STMAX) ? 16'h0020 : 16'h0000;
  endfunction : stFlag

  assign bufReadData = sampleAt(bufReadAddr);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Sensor output moves by the stimulus response while the stimulus is on
  always @(negedge clk) accelSample <= stimulusOn ? base + dlt : base;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (captureStart) begin
      starts <= starts + 1;
      startAddr <= bufReadAddr;
    end
    if (cycles == 60000) begin
      fails++;
      results();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmpFlag(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask : cmpFlag
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, rx);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    host.xfer({1'b0, a, 8'h00}, rx);
    host.xfer({1'b0, a, 8'h00}, rx);
  endtask : rd
  task automatic capture;
    int s;
    s = starts;
    wr(vsr_pkg::ADDR_GCMD_HIGH, 8'h08);
    cmp(16'(starts - s), 16'h0001);
    cmp({6'h00, startAddr}, 16'h0000);
    captureBusy = 1'b1;
    repeat (40) @(negedge clk);
    captureBusy = 1'b0;
    // Host holds off until the capture engine is idle
    repeat (4) @(negedge clk);
  endtask : capture
  task automatic selfTest(input logic signed [15:0] d);
    base = 16'($urandom_range(0, 16'h3fff)) - 16'sh2000;
    dlt = d;
    wr(vsr_pkg::ADDR_GCMD_LOW, 8'h04);
    repeat (2500) @(negedge clk);
    cmpFlag(stimulusOn, 1'b1);
    repeat (1600) @(negedge clk);
    cmpFlag(stimulusOn, 1'b0);
    rd(vsr_pkg::ADDR_SELFTEST_DELTA);
    cmp(rx, d);
    rd(vsr_pkg::ADDR_DIAG);
    cmp(rx & 16'h0020, stFlag(d));
  endtask : selfTest
  task results;
    if (fails == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial begin
    reset = 1'b1;
    captureBusy = 1'b0;
    flashWriteDone = 1'b0;
    void'($urandom(32'ha217));
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    cmpFlag(auxOneComp, 1'b1);
    cmpFlag(auxTwoComp, 1'b1);
    cmpFlag(spiMisoOe, 1'b0);
    rd(vsr_pkg::ADDR_MISC_LOW);
    cmp(rx, vsr_pkg::MISC_RESET);
    for (int k = 0; k < 4; k++) begin
      dat = (8'($urandom()) & 8'hfc) | 8'(k);
      wr(vsr_pkg::ADDR_MISC_LOW, dat);
      rd(vsr_pkg::ADDR_MISC_LOW);
      cmp(rx, {14'h0000, dat[1:0]});
      cmpFlag(auxOneComp, dat[0]);
      cmpFlag(auxTwoComp, dat[1]);
    end
    // Writes to read-only places must leave them untouched
    wr(vsr_pkg::ADDR_LOT_LOW + 7'h01, 8'($urandom()));
    wr(vsr_pkg::ADDR_LOT_HIGH, 8'($urandom()));
    wr(vsr_pkg::ADDR_SERIAL, 8'($urandom()));
    wr(vsr_pkg::ADDR_FLASH_COUNT, 8'($urandom()));
    rd(vsr_pkg::ADDR_LOT_LOW);
    cmp({rx[15:8], 8'h00}, {LOT[7:0], 8'h00});
    rd(vsr_pkg::ADDR_LOT_HIGH);
    cmp(rx, LOT[23:8]);
    rd(vsr_pkg::ADDR_SERIAL);
    cmp(rx, SER);
    nf = $urandom_range(3, 9);
    for (int k = 0; k < nf; k++) begin
      @(negedge clk);
      flashWriteDone = 1'b1;
      @(negedge clk);
      flashWriteDone = 1'b0;
    end
    rd(vsr_pkg::ADDR_FLASH_COUNT);
    cmp(rx, 16'(nf));
    capture();
    fork
      host.xfer(16'h1400, rx);
      begin
        repeat (100) @(negedge clk);
        cmpFlag(spiMisoOe, 1'b1);
      end
    join
    nf = $urandom_range(4, 8);
    for (int n = 0; n < nf; n++) begin
      host.xfer(16'h1400, rx);
      cmp(rx, sampleAt(10'(n)));
    end
    // Traffic during a capture raises the violation flag until cleared
    captureBusy = 1'b1;
    host.xfer(16'h0000, rx);
    captureBusy = 1'b0;
    rd(vsr_pkg::ADDR_DIAG);
    cmp(rx & 16'h0010, 16'h0010);
    rd(vsr_pkg::ADDR_DIAG);
    cmp(rx & 16'h0010, 16'h0010);
    wr(vsr_pkg::ADDR_GCMD_LOW, 8'h10);
    rd(vsr_pkg::ADDR_DIAG);
    cmp(rx & 16'h0010, 16'h0000);
    stVals = '{16'($urandom_range(16, 1024)), 16'sh0401, 16'sh0010, -16'sh0100};
    for (int k = 0; k < 4; k++) begin
      selfTest(stVals[k]);
    end
    wr(vsr_pkg::ADDR_MISC_HIGH, 8'h01);
    cmpFlag(stimulusOn, 1'b1);
    rd(vsr_pkg::ADDR_MISC_LOW);
    cmp(rx & 16'h0100, 16'h0100);
    capture();
    cmpFlag(stimulusOn, 1'b0);
    rd(vsr_pkg::ADDR_MISC_LOW);
    cmp(rx & 16'h0100, 16'h0000);
    rd(vsr_pkg::ADDR_DIAG);
    cmp(rx & 16'h0020, 16'h0000);
    // Second reset in mid-run brings misc control back to its reset value
    wr(vsr_pkg::ADDR_MISC_LOW, 8'h00);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    cmpFlag(auxOneComp, 1'b1);
    rd(vsr_pkg::ADDR_MISC_LOW);
    cmp(rx, vsr_pkg::MISC_RESET);
    results();
  end
endmodule : vsr_regs_tb
`default_nettype wire
